// ### lsc_top.sv
// lamp controller configuration: register bank on APB and the logic it steers
//
// Overview of operation
// - three-bit code picks duty 0..19% in 3% steps, one percent more for codes 4-6; code 7 keeps last duty
// - each duty code covers two consecutive lamp cycles of soft-start
// - two-bit field sets timeout 32768, 65536 or 98304 lamp cycles; 11 reserved
// - the chosen timeout governs both lamp channels alike
// - control bit 0 gates lamp overcurrent detection on
// - oscillator select: resistor-set internal oscillator, or external 22.5-440 Hz clock
// - lamp frequency made and driven on lamp sync pin, or taken from it
// - dimming signal made and driven on dimming sync pin, or taken from it
// - ramp option puts ramp generator instead of dimming signal on dimming sync
// - automatic retry after fault unless autoretry disable is set
// - fault response: shut faulty channel only, or both channels
// - dimming disable bit turns digital dimming off
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "lsc_map.svh"

module lsc_top #(
	parameter int LAMP_DIV = `LSC_LAMP_DIV,      // clocks per internal lamp cycle
	parameter int TO_UNIT  = `LSC_TO_UNIT        // lamp cycles per timeout step
) (
	input  wire logic        pclk,               // system clock, 250 MHz
	input  wire logic        presetn,            // async reset, active low
	input  wire logic        psel,               // apb select
	input  wire logic        penable,            // apb access phase
	input  wire logic        pwrite,             // apb write
	input  wire logic [11:0] paddr,              // apb byte address
	input  wire logic [31:0] pwdata,             // apb write data
	output logic [31:0]      prdata,             // apb read data
	output logic             pready,             // apb ready
	output logic             pslverr,            // apb error on unmapped address or status write
	input  wire logic [1:0]  ch_enable,          // channel on requests
	input  wire logic [1:0]  strike_ok,          // lamp struck, per channel
	input  wire logic [1:0]  lamp_out,           // lamp out, per channel
	input  wire logic [1:0]  overcurrent,        // lamp overcurrent, per channel
	input  wire logic        dim_osc_input,      // dimming oscillator pin
	input  wire logic        dim_pwm_int,        // internal dimming signal
	input  wire logic        ramp_int,           // internal ramp generator
	input  wire logic        lamp_sync_pin_i,    // lamp sync pin level
	output logic             lamp_sync_pin_o,    // lamp sync pin drive
	output logic             lamp_sync_pin_oe_n, // lamp sync pin enable, low drives
	input  wire logic        dim_sync_pin_i,     // dimming sync pin level
	output logic             dim_sync_pin_o,     // dimming sync pin drive
	output logic             dim_sync_pin_oe_n,  // dimming sync pin enable, low drives
	output logic             dim_osc_ext,        // oscillator taken from external clock
	output logic             dim_osc_tick,       // one pulse per rising external dimming clock edge
	output logic             digital_dimming_pwm,// dimming gate to the lamp drive
	output logic [1:0]       ch_drive_en,        // channel lamp drive on
	output logic [9:0]       ch_duty,            // per channel duty in percent, 5 bits each
	output logic [1:0]       ch_fault            // channel fault
);

	// ****************************************
	// apb register bank
	// ****************************************
	logic [7:0]  ssp [4];
	logic [7:0]  control_one;
	logic [7:0]  rd_byte;
	wire  [9:0]  idx        = paddr[11:2];
	wire         acc        = psel && penable;
	wire         wr_en      = acc && pwrite;
	wire         hit_ssp    = idx >= {2'b00, `LSC_IDX_SSP1} && idx <= {2'b00, `LSC_IDX_SSP4};
	wire         hit_ctrl   = idx == {2'b00, `LSC_IDX_CTRL1};
	wire         hit_stat   = idx == {2'b00, `LSC_IDX_STAT};
	wire         mapped     = hit_ssp || hit_ctrl || (hit_stat && !pwrite);
	wire  [1:0]  ssp_sel    = idx[1:0];
	wire  [7:0]  ssp_wmask  = (ssp_sel == 2'h0) ? 8'hFF : `LSC_SSP_RSVD_MASK;

	lsc_pkg::lsc_state_t ch_state [2];
	logic [1:0]          chan_fault;

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign rd_byte = hit_ssp  ? ssp[ssp_sel] :
	                 hit_ctrl ? control_one :
	                 hit_stat ? {2'b00, ch_state[1], ch_state[0], chan_fault} : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssp[0]      <= `LSC_RST_SSP1;
			ssp[1]      <= `LSC_RST_SSP2;
			ssp[2]      <= `LSC_RST_SSP3;
			ssp[3]      <= `LSC_RST_SSP4;
			control_one <= `LSC_RST_CTRL1;
			prdata      <= 32'h0000_0000;
		end else begin
			if (wr_en && hit_ssp) ssp[ssp_sel] <= pwdata[7:0] & ssp_wmask;
			if (wr_en && hit_ctrl) control_one <= pwdata[7:0];
			if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ****************************************
	// control decode
	// ****************************************
	wire        oc_en      = control_one[`LSC_CR_OC_EN];
	wire        osc_sel    = control_one[`LSC_CR_OSC_SEL];
	wire        lfreq_ext  = control_one[`LSC_CR_LFREQ_SEL];
	wire        dsig_ext   = control_one[`LSC_CR_DSIG_SEL];
	wire        ramp_sel   = control_one[`LSC_CR_RAMP_SEL];
	wire        retry_off  = control_one[`LSC_CR_RETRY_OFF];
	wire        fault_all  = control_one[`LSC_CR_FAULT_ALL];
	wire        dim_off    = control_one[`LSC_CR_DIM_OFF];
	wire [1:0]  to_sel     = {ssp[0][`LSC_SSP_TO_HI], ssp[0][`LSC_SSP_TO_LO]};
	// reserved setting falls back to the longest limit
	wire [1:0]  to_mult    = (to_sel == 2'b11) ? 2'b10 : to_sel;
	wire [16:0] timeout    = 17'(TO_UNIT) * 17'({1'b0, to_mult} + 3'h1);
	wire [23:0] codes      = {ssp[3][6:4], ssp[3][2:0], ssp[2][6:4], ssp[2][2:0],
	                          ssp[1][6:4], ssp[1][2:0], ssp[0][6:4], ssp[0][2:0]};

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [10:0] sync_a;
	logic [10:0] sync_b;
	wire  [10:0] pins_raw = {dim_osc_input, lamp_sync_pin_i, dim_sync_pin_i,
	                         ch_enable, strike_ok, lamp_out, overcurrent};
	logic        osc_q;
	logic        lamp_pin_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a  <= 11'h000;
			sync_b  <= 11'h000;
			osc_q   <= 1'b0;
			lamp_pin_q <= 1'b0;
		end else begin
			sync_a  <= pins_raw;
			sync_b  <= sync_a;
			osc_q   <= sync_b[10];
			lamp_pin_q <= sync_b[9];
		end
	end

	wire [1:0] en_s  = sync_b[7:6];
	wire [1:0] so_s  = sync_b[5:4];
	wire [1:0] lo_s  = sync_b[3:2];
	wire [1:0] oc_s  = sync_b[1:0];

	// ****************************************
	// lamp frequency and dimming pins
	// ****************************************
	logic [15:0] lamp_div_cnt;
	logic        lamp_clk_int;
	wire         div_wrap  = lamp_div_cnt == 16'(LAMP_DIV - 1);
	wire         ext_tick  = sync_b[9] && !lamp_pin_q;
	wire         lamp_tick = lfreq_ext ? ext_tick : div_wrap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lamp_div_cnt <= 16'h0000;
			lamp_clk_int <= 1'b0;
		end else begin
			lamp_div_cnt <= div_wrap ? 16'h0000 : lamp_div_cnt + 16'h0001;
			if (div_wrap) lamp_clk_int <= 1'b0;
			else if (lamp_div_cnt == 16'(LAMP_DIV / 2 - 1)) lamp_clk_int <= 1'b1;
		end
	end

	assign lamp_sync_pin_o     = lamp_clk_int;
	assign lamp_sync_pin_oe_n  = lfreq_ext;
	assign dim_sync_pin_o      = ramp_sel ? ramp_int : dim_pwm_int;
	assign dim_sync_pin_oe_n   = dsig_ext;
	assign dim_osc_ext         = osc_sel;
	assign dim_osc_tick        = osc_sel && sync_b[10] && !osc_q;
	// disabled dimming leaves the lamp burst gate fully on
	assign digital_dimming_pwm = dim_off ? 1'b1 : (dsig_ext ? sync_b[8] : dim_pwm_int);

	// ****************************************
	// lamp channels
	// ****************************************
	wire [1:0] other_down = {chan_fault[0], chan_fault[1]} & {2{fault_all}};

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [4:0] duty_c;
		lsc_chan u_chan (
			.pclk              (pclk),
			.presetn           (presetn),
			.lamp_tick         (lamp_tick),
			.enable            (en_s[c]),
			.shutdown          (other_down[c]),
			.strike_ok         (so_s[c]),
			.lamp_out          (lo_s[c]),
			.overcurrent       (oc_s[c]),
			.oc_detect_en      (oc_en),
			.autoretry_disable (retry_off),
			.timeout_cycles    (timeout),
			.codes             (codes),
			.duty              (duty_c),
			.state             (ch_state[c]),
			.fault             (chan_fault[c])
		);
		assign ch_duty[c*5 +: 5] = duty_c;
		assign ch_drive_en[c]    = ch_state[c] inside {lsc_pkg::LSC_SOFT, lsc_pkg::LSC_RUN};
	end

	assign ch_fault = chan_fault;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	timeout_value_a: assert property (to_sel == 2'b01 |-> timeout == 17'(2 * TO_UNIT))
		else $error("timeout select 01 wrong");
	shared_limit_a: assert property (1'b1 |-> g_ch[0].u_chan.timeout_cycles == g_ch[1].u_chan.timeout_cycles)
		else $error("channels use different limits");
	both_down_a: assert property (fault_all && chan_fault[0] && ch_state[1] != lsc_pkg::LSC_FAULT
		|=> ch_state[1] == lsc_pkg::LSC_IDLE) else $error("fault did not shut other channel");
	lamp_pin_a: assert property (lfreq_ext |-> lamp_sync_pin_oe_n && lamp_tick == ext_tick)
		else $error("lamp sync driven while external");
	dim_pin_a: assert property (!dsig_ext |-> !dim_sync_pin_oe_n ##0 dim_sync_pin_o == (ramp_sel ? ramp_int : dim_pwm_int))
		else $error("dimming sync pin source wrong");
	dim_off_a: assert property (dim_off |-> digital_dimming_pwm)
		else $error("dimming active while disabled");
	ctrl_write_a: assert property (wr_en && hit_ctrl |=> control_one == $past(pwdata[7:0]))
		else $error("control write lost");
	osc_tick_a: assert property (!osc_sel |-> !dim_osc_tick)
		else $error("external oscillator used while internal");

	apb_write_c: cover property (wr_en && hit_ctrl);
	fault_c:     cover property (chan_fault[0] ##1 ch_state[1] == lsc_pkg::LSC_IDLE);
	unmapped_c:  cover property (pslverr);

endmodule : lsc_top

// ### lsc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// ****************************************
// register indices (byte address is four times the index)
// ****************************************
`define LSC_IDX_SSP1        8'hF0
`define LSC_IDX_SSP2        8'hF1
`define LSC_IDX_SSP3        8'hF2
`define LSC_IDX_SSP4        8'hF3
`define LSC_IDX_CTRL1       8'hF4
`define LSC_IDX_STAT        8'hF5

// ****************************************
// reset values
// ****************************************
`define LSC_RST_SSP1        8'h21
`define LSC_RST_SSP2        8'h43
`define LSC_RST_SSP3        8'h65
`define LSC_RST_SSP4        8'h77
`define LSC_RST_CTRL1       8'h00

// ****************************************
// soft-start register fields
// ****************************************
`define LSC_SSP_CODE_LO     0
`define LSC_SSP_TO_LO       3
`define LSC_SSP_CODE_HI     4
`define LSC_SSP_TO_HI       7
`define LSC_SSP_RSVD_MASK   8'h77
`define LSC_CODE_HOLD       3'h7
`define LSC_DUTY_STEP       5'h03

// ****************************************
// control register one fields
// ****************************************
`define LSC_CR_OC_EN        0
`define LSC_CR_OSC_SEL      1
`define LSC_CR_LFREQ_SEL    2
`define LSC_CR_DSIG_SEL     3
`define LSC_CR_RAMP_SEL     4
`define LSC_CR_RETRY_OFF    5
`define LSC_CR_FAULT_ALL    6
`define LSC_CR_DIM_OFF      7

// ****************************************
// timing
// ****************************************
`define LSC_CLK_PERIOD_NS   4
`define LSC_CLK_HZ          (1_000_000_000 / `LSC_CLK_PERIOD_NS)
`define LSC_LAMP_HZ         50_000
`define LSC_LAMP_DIV        (`LSC_CLK_HZ / `LSC_LAMP_HZ)
`define LSC_TO_UNIT         32768
`define LSC_SOFT_LAST       4'hF

`endif

// ### lsc_pkg.sv
// types shared by the lamp soft-start configuration block
package lsc_pkg;

	typedef enum logic [1:0] {
		LSC_IDLE  = 2'b00,
		LSC_SOFT  = 2'b01,
		LSC_RUN   = 2'b11,
		LSC_FAULT = 2'b10
	} lsc_state_t;

endpackage : lsc_pkg

// ### lsc_chan.sv
// one lamp channel: soft-start duty sequence, strike and lamp-out timeout, fault handling
`timescale 1ns/10ps
`include "lsc_map.svh"

module lsc_chan (
	input  wire logic              pclk,              // system clock
	input  wire logic              presetn,           // async reset, active low
	input  wire logic              lamp_tick,         // one pulse per lamp cycle
	input  wire logic              enable,            // channel wanted on
	input  wire logic              shutdown,          // forced off by the other channel
	input  wire logic              strike_ok,         // lamp has struck
	input  wire logic              lamp_out,          // lamp current missing
	input  wire logic              overcurrent,       // lamp current too high
	input  wire logic              oc_detect_en,      // overcurrent detection gate
	input  wire logic              autoretry_disable, // no retry after a fault
	input  wire logic [16:0]       timeout_cycles,    // strike/lamp-out limit in lamp cycles
	input  wire logic [23:0]       codes,             // eight three-bit duty codes
	output logic [4:0]             duty,              // switching duty in percent
	output lsc_pkg::lsc_state_t    state,             // channel state
	output logic                   fault              // channel in fault
);

	lsc_pkg::lsc_state_t next_state;
	logic [16:0]         cnt;
	logic [3:0]          cyc;
	logic [2:0]          cur_code;
	logic [4:0]          next_duty;
	logic [4:0]          code_duty;
	wire                 cnt_done  = lamp_tick && (cnt == timeout_cycles - 17'h0_0001);
	wire                 oc_trip   = oc_detect_en && overcurrent;
	wire                 soft_done = (cyc == `LSC_SOFT_LAST);

	// each code covers a pair of lamp cycles
	assign cur_code  = codes[{cyc[3:1], 2'b00} - {2'b00, cyc[3:1]} +: 3];
	// upper codes sit one percent above the plain three-percent step
	assign code_duty = 5'(cur_code * `LSC_DUTY_STEP) + {4'h0, cur_code[2]};
	assign next_duty = (cur_code == `LSC_CODE_HOLD) ? duty : code_duty;
	assign fault     = (state == lsc_pkg::LSC_FAULT);

	always_comb begin
		next_state = state;
		case (state)
			// start on a lamp cycle boundary so every code pair spans two whole cycles
			lsc_pkg::LSC_IDLE:  if (enable && !shutdown && lamp_tick) next_state = lsc_pkg::LSC_SOFT;
			lsc_pkg::LSC_SOFT: begin
				if (oc_trip || cnt_done) next_state = lsc_pkg::LSC_FAULT;
				else if (strike_ok && soft_done && lamp_tick) next_state = lsc_pkg::LSC_RUN;
			end
			lsc_pkg::LSC_RUN:   if (oc_trip || (lamp_out && cnt_done)) next_state = lsc_pkg::LSC_FAULT;
			lsc_pkg::LSC_FAULT: if (!autoretry_disable && cnt_done) next_state = lsc_pkg::LSC_IDLE;
			default:            next_state = lsc_pkg::LSC_IDLE;
		endcase
		if (!enable || (shutdown && state != lsc_pkg::LSC_FAULT)) next_state = lsc_pkg::LSC_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= lsc_pkg::LSC_IDLE;
			cnt   <= 17'h0_0000;
			cyc   <= 4'h0;
			duty  <= 5'h00;
		end else begin
			state <= next_state;
			if (next_state != state || (state == lsc_pkg::LSC_RUN && !lamp_out)) cnt <= 17'h0_0000;
			else if (lamp_tick) cnt <= cnt + 17'h0_0001;
			if (state != lsc_pkg::LSC_SOFT) cyc <= 4'h0;
			else if (lamp_tick && !soft_done) cyc <= cyc + 4'h1;
			if (state == lsc_pkg::LSC_SOFT) duty <= next_duty;
			else if (state != lsc_pkg::LSC_RUN) duty <= 5'h00;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	strike_timeout_a: assert property (state == lsc_pkg::LSC_SOFT && cnt_done && enable && !shutdown
		|=> state == lsc_pkg::LSC_FAULT) else $error("strike timeout did not fault");
	oc_gate_a: assert property (state == lsc_pkg::LSC_RUN && !oc_detect_en && !lamp_out && enable && !shutdown
		|=> state == lsc_pkg::LSC_RUN) else $error("overcurrent acted while gated");
	oc_trip_a: assert property (state inside {lsc_pkg::LSC_SOFT, lsc_pkg::LSC_RUN} && oc_trip && enable && !shutdown
		|=> fault) else $error("overcurrent did not fault");
	retry_off_a: assert property (fault && autoretry_disable && enable
		|=> fault) else $error("retried while autoretry disabled");
	duty_code_a: assert property (state == lsc_pkg::LSC_SOFT && cur_code != `LSC_CODE_HOLD
		|=> duty == 5'($past(cur_code)) * 5'h03 + {4'h0, $past(cur_code[2])})
		else $error("duty does not follow code");
	duty_hold_a: assert property (state == lsc_pkg::LSC_SOFT && cur_code == `LSC_CODE_HOLD
		|=> $stable(duty)) else $error("hold code changed duty");
	pair_index_a: assert property (state == lsc_pkg::LSC_SOFT && lamp_tick && !cyc[0] && !soft_done
		|=> cur_code == $past(cur_code) || state != lsc_pkg::LSC_SOFT) else $error("code changed inside a pair");

	soft_run_c: cover property (state == lsc_pkg::LSC_SOFT ##1 state == lsc_pkg::LSC_RUN);
	retry_c:    cover property (fault ##1 state == lsc_pkg::LSC_IDLE);

endmodule : lsc_chan

// ### lsc_top_tb.sv
// self-checking bench for the lamp soft-start configuration block
`timescale 1ns/10ps
`include "lsc_map.svh"

module lsc_top_tb;
	localparam int DIV  = 8;
	localparam int UNIT = 32;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic [1:0]  ch_enable = 2'b00, strike_ok = 2'b00, lamp_out = 2'b00, overcurrent = 2'b00;
	logic        dim_osc_input = 1'b0, dim_pwm_int = 1'b0, ramp_int = 1'b0;
	logic        lamp_sync_pin_i = 1'b0, dim_sync_pin_i = 1'b0;
	logic        lamp_sync_pin_o, lamp_sync_pin_oe_n, dim_sync_pin_o, dim_sync_pin_oe_n;
	logic        dim_osc_ext, dim_osc_tick, digital_dimming_pwm;
	logic [1:0]  ch_drive_en, ch_fault;
	logic [9:0]  ch_duty;
	int          n_errors = 0, total_checks = 0, n_tick = 0;
	int          n_lamp_edge = 0, ext_cnt = 0;
	logic        lamp_o_d = 1'b0;
	bit          ext_lamp = 1'b0;

	// ****************************************
	// clock, design, tick counter
	// ****************************************
	always #2 pclk = ~pclk;

	lsc_top #(.LAMP_DIV(DIV), .TO_UNIT(UNIT)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ch_enable(ch_enable), .strike_ok(strike_ok),
		.lamp_out(lamp_out), .overcurrent(overcurrent), .dim_osc_input(dim_osc_input),
		.dim_pwm_int(dim_pwm_int), .ramp_int(ramp_int), .lamp_sync_pin_i(lamp_sync_pin_i),
		.lamp_sync_pin_o(lamp_sync_pin_o), .lamp_sync_pin_oe_n(lamp_sync_pin_oe_n),
		.dim_sync_pin_i(dim_sync_pin_i), .dim_sync_pin_o(dim_sync_pin_o),
		.dim_sync_pin_oe_n(dim_sync_pin_oe_n), .dim_osc_ext(dim_osc_ext), .dim_osc_tick(dim_osc_tick),
		.digital_dimming_pwm(digital_dimming_pwm), .ch_drive_en(ch_drive_en), .ch_duty(ch_duty),
		.ch_fault(ch_fault));

	// counts internal lamp clock edges and makes the external lamp clock, period 12
	always @(posedge pclk) begin
		lamp_o_d <= lamp_sync_pin_o;
		if (lamp_sync_pin_o === 1'b1 && lamp_o_d === 1'b0) begin
			n_lamp_edge++;
		end
		if (ext_lamp) begin
			ext_cnt <= (ext_cnt == 11) ? 0 : ext_cnt + 1;
			lamp_sync_pin_i <= (ext_cnt < 6);
		end
	end

	always @(posedge pclk) begin
		if (dim_osc_tick === 1'b1) begin
			n_tick++;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("ready", 32'h0000_0001, {31'h0, pready});
		if (!wr) begin
			chk("read data", {24'h00_0000, wd}, prdata);
		end
		chk("slave error", {31'h0, err}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// waits until drive enables (drv) or faults equal want
	task automatic until_sig(input bit drv, input logic [1:0] want, input int lim, output int c);
		c = 0;
		while ((drv ? ch_drive_en : ch_fault) !== want && c < lim) begin
			@(posedge pclk);
			c++;
		end
		chk("wait end", {30'h0, want}, {30'h0, (drv ? ch_drive_en : ch_fault)});
	endtask : until_sig

	task automatic near(input string what, input int exp, input int got);
		chk(what, exp, (got >= exp - DIV - 6 && got <= exp + DIV + 6) ? exp : got);
	endtask : near

	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	// watchdog: the whole sequence takes well under 10000 cycles
	initial begin
		#(40000 * `LSC_CLK_PERIOD_NS);
		n_errors++;
		give_verdict();
	end

	// ****************************************
	// main sequence
	// ****************************************
	logic [7:0] rv[5] = '{`LSC_RST_SSP1, `LSC_RST_SSP2, `LSC_RST_SSP3, `LSC_RST_SSP4, `LSC_RST_CTRL1};
	logic [7:0] cv[8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h18, 8'h80, 8'h9e};
	logic [4:0] ev[7] = '{5'h06, 5'h0d, 5'h00, 5'h13, 5'h10, 5'h09, 5'h03};
	logic [4:0] vals[8], last;
	int         at[8], nchg, c, t, ex;
	logic       pl;

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, `LSC_IDX_SSP1 + 8'(i), rv[i], 1'b0);
		end
		apb(1'b1, `LSC_IDX_CTRL1, 8'ha5, 1'b0);
		apb(1'b0, `LSC_IDX_CTRL1, 8'ha5, 1'b0);
		apb(1'b1, `LSC_IDX_SSP2, 8'hff, 1'b0);
		apb(1'b0, `LSC_IDX_SSP2, 8'h77, 1'b0);
		apb(1'b0, 8'h10, 8'h00, 1'b1);
		apb(1'b1, `LSC_IDX_STAT, 8'h00, 1'b1);
		// duty codes 2,7,4,0,6,5,3,1 with a hold code in the second pair
		apb(1'b1, `LSC_IDX_SSP1, 8'h72, 1'b0);
		apb(1'b1, `LSC_IDX_SSP2, 8'h04, 1'b0);
		apb(1'b1, `LSC_IDX_SSP3, 8'h56, 1'b0);
		apb(1'b1, `LSC_IDX_SSP4, 8'h13, 1'b0);
		apb(1'b1, `LSC_IDX_CTRL1, 8'h20, 1'b0);
		strike_ok <= 2'b11;
		ch_enable <= 2'b01;
		nchg = 0;
		last = 5'h00;
		for (t = 0; t < 400; t++) begin
			@(posedge pclk);
			if (ch_duty[4:0] !== last && nchg < 8) begin
				vals[nchg] = ch_duty[4:0];
				at[nchg] = t;
				last = ch_duty[4:0];
				nchg++;
			end
		end
		chk("duty changes", 7, nchg);
		for (int i = 0; i < 7; i++) begin
			chk("duty", ev[i], vals[i]);
		end
		for (int i = 1; i < 7; i++) begin
			chk("duty span", (i == 1) ? 4 * DIV : 2 * DIV, at[i] - at[i-1]);
		end
		chk("run drive", 2'b01, ch_drive_en);
		ch_enable <= 2'b00;
		strike_ok <= 2'b00;
		cyc(10);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, `LSC_IDX_SSP1, {s[1], 3'b010, s[0], 3'b001}, 1'b0);
			ch_enable <= 2'b11;
			until_sig(1'b1, 2'b11, 50, c);
			until_sig(1'b0, 2'b11, 2000, c);
			ex = (s + 1) * UNIT * DIV;
			near("timeout", ex, c);
			cyc(ex + 50);
			chk("fault held", 2'b11, ch_fault);
			ch_enable <= 2'b00;
			cyc(10);
		end
		apb(1'b1, `LSC_IDX_SSP1, 8'h21, 1'b0);
		apb(1'b1, `LSC_IDX_CTRL1, 8'h00, 1'b0);
		ch_enable <= 2'b01;
		until_sig(1'b0, 2'b01, 800, c);
		until_sig(1'b0, 2'b00, 800, c);
		near("retry", UNIT * DIV, c);
		ch_enable <= 2'b00;
		cyc(10);
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, `LSC_IDX_CTRL1, f ? 8'h20 : 8'h60, 1'b0);
			strike_ok <= 2'b10;
			ch_enable <= 2'b11;
			until_sig(1'b0, 2'b01, 800, c);
			cyc(4);
			chk("fault shutdown", f ? 2'b10 : 2'b00, ch_drive_en);
			if (f == 1) begin
				chk("duty after fault", {5'h03, 5'h00}, ch_duty);
			end
			if (f == 0) begin
				ch_enable <= 2'b00;
				cyc(10);
			end
		end
		cyc(300);
		overcurrent <= 2'b10;
		cyc(20);
		chk("overcurrent off", 2'b01, ch_fault);
		apb(1'b1, `LSC_IDX_CTRL1, 8'h21, 1'b0);
		cyc(20);
		chk("overcurrent on", 2'b11, ch_fault);
		apb(1'b0, `LSC_IDX_STAT, 8'h2b, 1'b0);
		overcurrent <= 2'b00;
		ch_enable <= 2'b00;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `LSC_IDX_CTRL1, cv[i], 1'b0);
			for (int p = 0; p < 2; p++) begin
				pl = p[0];
				dim_pwm_int <= pl;
				ramp_int <= !pl;
				dim_sync_pin_i <= !pl;
				cyc(5);
				chk("lamp sync enable", cv[i][2], lamp_sync_pin_oe_n);
				chk("dim sync enable", cv[i][3], dim_sync_pin_oe_n);
				chk("osc external", cv[i][1], dim_osc_ext);
				chk("dim sync out", cv[i][4] ? !pl : pl, dim_sync_pin_o);
				chk("dim gate", cv[i][7] ? 1'b1 : (cv[i][3] ? !pl : pl), digital_dimming_pwm);
			end
		end
		for (int o = 0; o < 2; o++) begin
			apb(1'b1, `LSC_IDX_CTRL1, o ? 8'h00 : 8'h02, 1'b0);
			c = n_tick;
			repeat (3) begin
				dim_osc_input <= 1'b1;
				cyc(6);
				dim_osc_input <= 1'b0;
				cyc(6);
			end
			chk("osc ticks", o ? 0 : 3, n_tick - c);
		end
		c = n_lamp_edge;
		cyc(10 * DIV);
		chk("lamp sync edges", 10, n_lamp_edge - c);
		// external lamp clock drives soft-start, then the running lamp goes out
		apb(1'b1, `LSC_IDX_CTRL1, 8'h24, 1'b0);
		ext_lamp <= 1'b1;
		strike_ok <= 2'b01;
		ch_enable <= 2'b01;
		cyc(20 * 12);
		apb(1'b0, `LSC_IDX_STAT, 8'h0c, 1'b0);
		lamp_out <= 2'b01;
		until_sig(1'b0, 2'b01, 1000, c);
		near("lamp out timeout", UNIT * 12, c);
		give_verdict();
	end
endmodule : lsc_top_tb
